// >>> inc/rtc_pkg.sv
/*
  Shared constants and types for the locked indirect port of the real time
  clock: APB offsets, key codes, field positions, reset values, internal
  register map and timing counts. Assumes a 40 MHz system clock.
*/
package rtc_pkg;
  // apb byte offsets of the three directly mapped registers
  localparam logic [7:0] KEY_OFFSET = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] DATA_OFFSET = 8'h08;

  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  localparam logic [7:0] PIN_SHORT_CODE = 8'he7;

  // lock status codes as read back from the key register
  localparam logic [7:0] STAT_LOCKED = 8'h00;
  localparam logic [7:0] STAT_FIRST_KEY = 8'h01;
  localparam logic [7:0] STAT_UNLOCKED = 8'h02;
  localparam logic [7:0] STAT_DISABLED = 8'h03;

  // indirect address register fields
  localparam int ADR_BUSY_BIT = 7;
  localparam int ADR_AUTO_READ_BIT = 6;
  localparam int ADR_SHORT_BIT = 4;
  localparam int ADR_INDEX_W = 4;
  localparam logic ADR_SHORT_RESET = 1'b1;

  // internal register map
  localparam logic [3:0] INT_CAPTURE_FIRST = 4'h0;
  localparam logic [3:0] INT_CAPTURE_LAST = 4'h3;
  localparam logic [3:0] INT_OSC_CONTROL = 4'h4;
  localparam logic [3:0] INT_LOAD_CONFIG = 4'h5;
  localparam logic [3:0] INT_PIN_CONTROL = 4'h6;
  localparam logic [3:0] INT_ALARM_FIRST = 4'h8;
  localparam logic [3:0] INT_ALARM_LAST = 4'hb;

  // oscillator control byte fields
  localparam int OSC_POWER_BIT = 7;
  localparam int OSC_MODE_BIT = 6;
  localparam int OSC_GAIN_BIT = 5;
  localparam int OSC_BIAS_BIT = 4;
  localparam int OSC_MCLK_BIT = 3;
  localparam int OSC_VALID_BIT = 1;
  localparam int OSC_FAIL_BIT = 0;
  localparam logic [7:0] OSC_CONTROL_RESET = 8'h00;

  // load capacitance byte fields
  localparam int LOAD_STEP_BIT = 7;
  localparam int LOAD_READY_BIT = 6;
  localparam int LOAD_CAP_W = 4;
  localparam logic [7:0] LOAD_CONFIG_RESET = 8'h80;
  localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STROBE_LONG = 7;
  localparam int STROBE_SHORT = 6;
  localparam int LOAD_STEP_TIME_NS = 100000;
  localparam int LOAD_STEP_CYCLES = LOAD_STEP_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    LOCK_LOCKED = 4'b0001,
    LOCK_FIRST_KEY = 4'b0010,
    LOCK_UNLOCKED = 4'b0100,
    LOCK_DISABLED = 4'b1000
  } lock_state_t;

  typedef struct packed {
    logic power_enable;
    logic mode_crystal;
    logic gain_enable;
    logic bias_double;
    logic missing_clock_enable;
    logic pins_shorted;
    logic [3:0] load_cap;
  } osc_ctrl_t;
endpackage

// >>> core/rtc_internal_regs.sv
/*
  Byte-wide internal register store of the real time clock, reached only
  through the indirect port. Assumes one write or one read per cycle; read
  data appear one cycle after the read strobe, from a register.
*/
module rtc_internal_regs #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 8
) (
  // clocking
  input wire logic clk,
  input wire logic ce,
  // access
  input wire logic write_en,
  input wire logic read_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] write_data,
  output logic [DATA_W-1:0] read_data
);
  // contents deliberately not reset: the clock keeps time across resets
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] read_data_reg = '0;

  always_ff @(posedge clk) begin
    if (ce && write_en) begin
      mem[addr] <= write_data;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && read_en) begin
      read_data_reg <= mem[addr];
    end
  end

  assign read_data = read_data_reg;
endmodule

// >>> core/rtc_indirect_port.sv
/*
  Lock-and-key indirect access port of the real time clock as an APB slave,
  with busy timing, short strobe, auto-read, auto-increment, oscillator
  configuration and load capacitance stepping. Assumes a 40 MHz clock, a
  synchronous active-high reset and oscillator status from outside pins.
*/
// Overview of operation
// [R1] internal registers reached only through key, address and data words
// [R2] keys 0xa5 then 0xf1 unlock the address and data registers
// [R3] wrong key, wrong order or locked access disables port until reset
// [R4] once unlocked, any number of indirect accesses are accepted
// [R5] any key write while unlocked locks the port again
// [R6] key read returns lock status and leaves the key sequence alone
// [R7] address register selects the internal register being accessed
// [R8] data register write moves the byte into the selected register
// [R9] writing busy as 1 copies selected register into data register
// [R10] busy stays 1 during a transfer and clears when it ends
// [R11] address and data registers keep their contents through reset
// [R12] transfer lasts seven cycles, six with short strobe
// [R13] short strobe is on after reset, switched by an address bit
// [R14] with auto-read, each data read launches the next indirect read
// [R15] software sets busy once per auto-read run, then waits per read
// [R16] address advances by one after capture or alarm byte accesses
// [R17] mode select 1 picks crystal, 0 picks self-oscillation
// [R18] pin control value 0xe7 shorts both oscillator pins
// [R19] bias doubling chooses about 20 kHz or 40 kHz self-oscillation
// [R20] auto stepping raises load from smallest to setting, then ready
// [R21] four-bit load setting gives sixteen steps, 4.0 to 13.5 pF
// [R22] software crystal start-up order ends with clearing wake flags
// [R23] lock status codes: locked, first key, unlocked, disabled
module rtc_indirect_port #(
  parameter int STEP_CYCLES = rtc_pkg::LOAD_STEP_CYCLES
) (
  // clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator
  input wire logic crystal_valid_pin,
  input wire logic oscillator_fail_pin,
  output rtc_pkg::osc_ctrl_t osc_ctrl,
  output logic load_cap_ready_flag
);
  localparam logic [2:0] LEN_LONG = 3'(rtc_pkg::STROBE_LONG);
  localparam logic [2:0] LEN_SHORT = 3'(rtc_pkg::STROBE_SHORT);
  localparam int STEP_W = $clog2(STEP_CYCLES + 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);

  rtc_pkg::lock_state_t lock_reg;
  logic [7:0] prdata_reg, osc_control_reg, load_config_reg, pin_control_reg;
  logic slverr_reg, short_reg, busy_reg, op_write_reg;
  // address/data words deliberately without reset
  logic [3:0] index_reg = '0; // R11
  logic auto_read_reg = 1'b0;
  logic [7:0] data_reg = '0; // R11
  logic [2:0] cnt_reg, len_reg;
  logic [3:0] load_cur_reg;
  logic [STEP_W-1:0] step_cnt_reg;
  logic [1:0] valid_sync_reg, fail_sync_reg;

  // apb decode
  logic setup, access;
  logic hit_key, hit_addr, hit_data, mapped;
  logic wr_key, wr_addr, wr_data, rd_key, rd_data;
  logic port_open, touch_port;
  logic start_read, start_write, done;
  logic [7:0] mem_rdata, int_rdata;
  logic [7:0] wbyte;

  assign setup = psel && !penable && ce;
  assign access = psel && penable && pready;
  assign pready = ce;
  assign hit_key = (paddr == rtc_pkg::KEY_OFFSET);
  assign hit_addr = (paddr == rtc_pkg::ADDR_OFFSET);
  assign hit_data = (paddr == rtc_pkg::DATA_OFFSET);
  assign mapped = hit_key || hit_addr || hit_data;
  assign wbyte = pwdata[7:0];
  assign wr_key = access && pwrite && hit_key && pstrb[0];
  assign wr_addr = access && pwrite && hit_addr && pstrb[0];
  assign wr_data = access && pwrite && hit_data && pstrb[0];
  assign rd_key = access && !pwrite && hit_key;
  assign rd_data = access && !pwrite && hit_data;
  assign port_open = (lock_reg == rtc_pkg::LOCK_UNLOCKED); // R4
  assign touch_port = access && (hit_addr || hit_data);

  // lock and key sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_reg <= rtc_pkg::LOCK_LOCKED;
    end else if (ce) begin
      case (lock_reg)
        rtc_pkg::LOCK_LOCKED: begin
          if (touch_port) begin
            lock_reg <= rtc_pkg::LOCK_DISABLED; // R3
          end else if (wr_key) begin
            lock_reg <= (wbyte == rtc_pkg::KEY_FIRST) ? // R2
              rtc_pkg::LOCK_FIRST_KEY : rtc_pkg::LOCK_DISABLED;
          end
        end
        rtc_pkg::LOCK_FIRST_KEY: begin
          if (touch_port) begin
            lock_reg <= rtc_pkg::LOCK_DISABLED; // R3
          end else if (wr_key) begin
            lock_reg <= (wbyte == rtc_pkg::KEY_SECOND) ? // R2
              rtc_pkg::LOCK_UNLOCKED : rtc_pkg::LOCK_DISABLED;
          end
        end
        rtc_pkg::LOCK_UNLOCKED: begin
          if (wr_key) begin
            lock_reg <= rtc_pkg::LOCK_LOCKED; // R5
          end
        end
        rtc_pkg::LOCK_DISABLED: lock_reg <= rtc_pkg::LOCK_DISABLED; // R3
        default: lock_reg <= rtc_pkg::LOCK_DISABLED;
      endcase
    end
  end

  // indirect transfers; new requests while busy are dropped
  assign start_write = wr_data && port_open && !busy_reg; // R8
  assign start_read = port_open && !busy_reg &&
    ((wr_addr && wbyte[rtc_pkg::ADR_BUSY_BIT]) || // R9
     (rd_data && auto_read_reg)); // R14
  assign done = busy_reg && (cnt_reg == len_reg);

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_reg <= 1'b0;
      op_write_reg <= 1'b0;
      cnt_reg <= 3'h0;
      len_reg <= LEN_SHORT;
    end else if (ce) begin
      if (start_write || start_read) begin
        busy_reg <= 1'b1; // R10
        op_write_reg <= start_write;
        cnt_reg <= 3'h1;
        // short bit written together with busy takes effect at once
        len_reg <= (wr_addr ? wbyte[rtc_pkg::ADR_SHORT_BIT] : short_reg) ?
          LEN_SHORT : LEN_LONG; // R12
      end else if (done) begin
        busy_reg <= 1'b0; // R10
        cnt_reg <= 3'h0;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 3'h1;
      end
    end
  end

  // short strobe bit: with busy, one of the two reset fields of the address register
  always_ff @(posedge clk) begin
    if (reset) begin
      short_reg <= rtc_pkg::ADR_SHORT_RESET; // R13
    end else if (ce && wr_addr && port_open && !busy_reg) begin
      short_reg <= wbyte[rtc_pkg::ADR_SHORT_BIT]; // R13
    end
  end

  // address index and auto-read: kept across reset
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_addr && port_open && !busy_reg) begin
        index_reg <= wbyte[rtc_pkg::ADR_INDEX_W-1:0]; // R7
        auto_read_reg <= wbyte[rtc_pkg::ADR_AUTO_READ_BIT];
      end else if (done &&
          ((index_reg >= rtc_pkg::INT_CAPTURE_FIRST &&
            index_reg <= rtc_pkg::INT_CAPTURE_LAST) ||
           (index_reg >= rtc_pkg::INT_ALARM_FIRST &&
            index_reg <= rtc_pkg::INT_ALARM_LAST))) begin
        index_reg <= index_reg + 4'h1; // R16
      end
    end
  end

  // data register: kept across reset
  always_ff @(posedge clk) begin
    if (ce) begin
      if (start_write) begin
        data_reg <= wbyte;
      end else if (done && !op_write_reg) begin
        data_reg <= int_rdata; // R9
      end
    end
  end

  // internal store; read issued a cycle early for its output register
  rtc_internal_regs #(
    .ADDR_W(rtc_pkg::ADR_INDEX_W),
    .DATA_W(8)
  ) rtc_internal_regs_inst (
    .clk(clk),
    .ce(ce),
    .write_en(done && op_write_reg), // R8
    .read_en(busy_reg && !op_write_reg && (cnt_reg == len_reg - 3'h1)),
    .addr(index_reg), // R7
    .write_data(data_reg),
    .read_data(mem_rdata)
  );

  // configuration bytes shadowed here so they can steer the oscillator
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_control_reg <= rtc_pkg::OSC_CONTROL_RESET;
      load_config_reg <= rtc_pkg::LOAD_CONFIG_RESET;
      pin_control_reg <= rtc_pkg::PIN_CONTROL_RESET;
    end else if (ce && done && op_write_reg) begin
      case (index_reg)
        rtc_pkg::INT_OSC_CONTROL: osc_control_reg <= data_reg;
        rtc_pkg::INT_LOAD_CONFIG: load_config_reg <= data_reg;
        rtc_pkg::INT_PIN_CONTROL: pin_control_reg <= data_reg;
        default: ;
      endcase
    end
  end

  // status pins are asynchronous to clk
  always_ff @(posedge clk) begin
    if (reset) begin
      valid_sync_reg <= 2'b00;
      fail_sync_reg <= 2'b00;
    end else if (ce) begin
      valid_sync_reg <= {valid_sync_reg[0], crystal_valid_pin};
      fail_sync_reg <= {fail_sync_reg[0], oscillator_fail_pin};
    end
  end

  // load stepping restarts from the smallest value on power-up or rewrite
  logic restart_step;
  logic [3:0] load_target;
  assign load_target = load_config_reg[rtc_pkg::LOAD_CAP_W-1:0]; // R21
  assign restart_step = done && op_write_reg &&
    (index_reg == rtc_pkg::INT_LOAD_CONFIG ||
     index_reg == rtc_pkg::INT_OSC_CONTROL);

  always_ff @(posedge clk) begin
    if (reset) begin
      load_cur_reg <= 4'h0;
      step_cnt_reg <= '0;
    end else if (ce) begin
      if (!load_config_reg[rtc_pkg::LOAD_STEP_BIT] ||
          load_cur_reg > load_target) begin
        load_cur_reg <= load_target;
        step_cnt_reg <= '0;
      end else if (restart_step ||
          !osc_control_reg[rtc_pkg::OSC_POWER_BIT]) begin
        load_cur_reg <= 4'h0; // R20
        step_cnt_reg <= '0;
      end else if (load_cur_reg != load_target) begin
        if (step_cnt_reg == STEP_LAST) begin
          load_cur_reg <= load_cur_reg + 4'h1; // R20
          step_cnt_reg <= '0;
        end else begin
          step_cnt_reg <= step_cnt_reg + 1'b1;
        end
      end
    end
  end

  assign load_cap_ready_flag = (load_cur_reg == load_target); // R20

  // status bits overlay the stored bytes on indirect reads
  always_comb begin
    int_rdata = mem_rdata;
    case (index_reg)
      rtc_pkg::INT_OSC_CONTROL: begin
        int_rdata = osc_control_reg;
        int_rdata[rtc_pkg::OSC_VALID_BIT] = valid_sync_reg[1];
        int_rdata[rtc_pkg::OSC_FAIL_BIT] = fail_sync_reg[1];
      end
      rtc_pkg::INT_LOAD_CONFIG: begin
        int_rdata = load_config_reg;
        int_rdata[rtc_pkg::LOAD_READY_BIT] = load_cap_ready_flag;
      end
      rtc_pkg::INT_PIN_CONTROL: int_rdata = pin_control_reg;
      default: int_rdata = mem_rdata;
    endcase
  end

  always_comb begin
    osc_ctrl.power_enable = osc_control_reg[rtc_pkg::OSC_POWER_BIT];
    osc_ctrl.mode_crystal = osc_control_reg[rtc_pkg::OSC_MODE_BIT]; // R17
    osc_ctrl.gain_enable = osc_control_reg[rtc_pkg::OSC_GAIN_BIT];
    osc_ctrl.bias_double = osc_control_reg[rtc_pkg::OSC_BIAS_BIT]; // R19
    osc_ctrl.missing_clock_enable = osc_control_reg[rtc_pkg::OSC_MCLK_BIT];
    osc_ctrl.pins_shorted =
      (pin_control_reg == rtc_pkg::PIN_SHORT_CODE); // R18
    osc_ctrl.load_cap = load_cur_reg; // R21
  end

  // read data sampled in the setup phase; closed port reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_reg <= 8'h00;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      slverr_reg <= !mapped;
      prdata_reg <= 8'h00; // R1
      if (paddr == rtc_pkg::KEY_OFFSET) begin
        case (lock_reg) // R6 R23
          rtc_pkg::LOCK_LOCKED: prdata_reg <= rtc_pkg::STAT_LOCKED;
          rtc_pkg::LOCK_FIRST_KEY: prdata_reg <= rtc_pkg::STAT_FIRST_KEY;
          rtc_pkg::LOCK_UNLOCKED: prdata_reg <= rtc_pkg::STAT_UNLOCKED;
          default: prdata_reg <= rtc_pkg::STAT_DISABLED;
        endcase
      end else if (paddr == rtc_pkg::ADDR_OFFSET && port_open) begin
        prdata_reg <= {busy_reg, auto_read_reg, 1'b0, short_reg, index_reg};
      end else if (paddr == rtc_pkg::DATA_OFFSET && port_open) begin
        prdata_reg <= data_reg;
      end
    end
  end

  assign prdata = {24'h000000, prdata_reg};
  assign pslverr = slverr_reg && access;

  a_fast_len: assert property (@(posedge clk) disable iff (reset || !ce) // R12
    $rose(busy_reg) && len_reg == 3'd6 |-> busy_reg[*6] ##1 !busy_reg)
    else $error("short strobe transfer not six cycles");
  a_long_len: assert property (@(posedge clk) disable iff (reset || !ce) // R12
    $rose(busy_reg) && len_reg == 3'd7 |-> busy_reg[*7] ##1 !busy_reg)
    else $error("normal transfer not seven cycles");
  a_bad_key: assert property (@(posedge clk) disable iff (reset) // R3
    ce && wr_key && lock_reg == rtc_pkg::LOCK_LOCKED && wbyte != 8'ha5
    |=> lock_reg == rtc_pkg::LOCK_DISABLED)
    else $error("wrong first key did not disable port");
  a_unlock_seq: assert property (@(posedge clk) disable iff (reset) // R2
    ce && wr_key && lock_reg == rtc_pkg::LOCK_FIRST_KEY && wbyte == 8'hf1
    |=> lock_reg == rtc_pkg::LOCK_UNLOCKED)
    else $error("second key did not unlock");
  a_relock_write: assert property (@(posedge clk) disable iff (reset) // R5
    ce && wr_key && port_open |=> lock_reg == rtc_pkg::LOCK_LOCKED)
    else $error("key write while open did not lock");
  a_disabled_sticky: assert property (@(posedge clk) disable iff (reset) // R3
    lock_reg == rtc_pkg::LOCK_DISABLED |=> lock_reg == rtc_pkg::LOCK_DISABLED)
    else $error("disabled port recovered without reset");
  a_key_read_quiet: assert property (@(posedge clk) disable iff (reset) // R6
    rd_key |=> $stable(lock_reg))
    else $error("key read disturbed lock state");
  a_locked_touch: assert property (@(posedge clk) disable iff (reset) // R3
    ce && touch_port && !port_open |=> lock_reg == rtc_pkg::LOCK_DISABLED)
    else $error("locked indirect access did not disable port");
  a_short_reset: assert property (@(posedge clk) // R13
    $fell(reset) |-> short_reg && !busy_reg)
    else $error("short strobe not enabled after reset");
  a_auto_inc: assert property (@(posedge clk) disable iff (reset || !ce) // R16
    done && index_reg <= 4'h3 |=> index_reg == $past(index_reg) + 4'h1)
    else $error("capture access did not advance address");
  a_read_launch: assert property (@(posedge clk) disable iff (reset) // R14
    ce && rd_data && auto_read_reg && port_open && !busy_reg |=> busy_reg)
    else $error("auto-read did not launch next read");
  a_pin_short: assert property (@(posedge clk) disable iff (reset) // R18
    ce && done && op_write_reg && index_reg == rtc_pkg::INT_PIN_CONTROL
    |=> osc_ctrl.pins_shorted == ($past(data_reg) == 8'he7))
    else $error("pin short does not follow written code");

  c_unlock: cover property (@(posedge clk) disable iff (reset)
    lock_reg == rtc_pkg::LOCK_FIRST_KEY ##[1:20] port_open);
  c_write_done: cover property (@(posedge clk) disable iff (reset)
    done && op_write_reg);
  c_auto_read: cover property (@(posedge clk) disable iff (reset)
    rd_data && auto_read_reg && start_read);
  c_disabled: cover property (@(posedge clk) disable iff (reset)
    $rose(lock_reg == rtc_pkg::LOCK_DISABLED));
endmodule

// >>> bench/testbench.sv
/*
  Self-checking bench for the locked indirect port of the real time clock:
  key sequence, indirect writes and reads, auto-read, auto-increment,
  oscillator fields, load stepping, lock loss and reset retention.
  Assumes the rtc_pkg package is compiled first; the master waits on pready.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // short names for the three word offsets
  localparam logic [7:0] A_KEY = rtc_pkg::KEY_OFFSET;
  localparam logic [7:0] A_ADR = rtc_pkg::ADDR_OFFSET;
  localparam logic [7:0] A_DAT = rtc_pkg::DATA_OFFSET;
  logic clk, reset, ce, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, load_cap_ready_flag, err;
  logic crystal_valid_pin, oscillator_fail_pin;
  rtc_pkg::osc_ctrl_t osc_ctrl;
  int err_total, check_count;

  // short step interval keeps the stepping wait small
  rtc_indirect_port #(.STEP_CYCLES(4)) rtc_indirect_port_inst (
    .clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_valid_pin(crystal_valid_pin),
    .oscillator_fail_pin(oscillator_fail_pin),
    .osc_ctrl(osc_ctrl), .load_cap_ready_flag(load_cap_ready_flag)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic stop_test();
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // the wait ends once pready is high; the watchdog catches a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(rd[7:0], exp);
  endtask

  task automatic wait_idle();
    int n = 0;
    do begin
      apb(1'b0, A_ADR, 8'h00);
      n++;
    end while (rd[7] !== 1'b0 && n < 30);
    check(8'(rd[7]), 8'h00);
  endtask

  // indirect write with short strobe; busy must show straight after
  task automatic ind_wr(input logic [3:0] idx, input logic [7:0] d);
    apb(1'b1, A_ADR, {4'h1, idx});
    apb(1'b1, A_DAT, d);
    apb(1'b0, A_ADR, 8'h00);
    check(8'(rd[7]), 8'h01);
    wait_idle();
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
  endtask

  task automatic t_unlock();
    rdchk(A_KEY, rtc_pkg::STAT_LOCKED);
    apb(1'b1, A_KEY, rtc_pkg::KEY_FIRST);
    rdchk(A_KEY, rtc_pkg::STAT_FIRST_KEY);
    apb(1'b1, A_KEY, rtc_pkg::KEY_SECOND);
    rdchk(A_KEY, rtc_pkg::STAT_UNLOCKED);
    apb(1'b0, 8'h0c, 8'h00);
    check(8'(err), 8'h01);
  endtask

  task automatic t_osc();
    ind_wr(4'h4, 8'h80);
    check(8'(osc_ctrl.mode_crystal), 8'h00);
    check(8'(osc_ctrl.power_enable), 8'h01);
    ind_wr(4'h4, 8'hd0);
    check(8'(osc_ctrl.mode_crystal), 8'h01);
    check(8'(osc_ctrl.bias_double), 8'h01);
    rdchk(A_ADR, 8'h14);
    ind_wr(4'h6, rtc_pkg::PIN_SHORT_CODE);
    check(8'(osc_ctrl.pins_shorted), 8'h01);
    ind_wr(4'h6, 8'he6);
    check(8'(osc_ctrl.pins_shorted), 8'h00);
  endtask

  // power must be on, or stepping stays parked at zero
  task automatic t_load_cap_setting();
    logic [3:0] tgt [2] = '{4'h3, 4'hf};
    int n;
    for (int i = 0; i < 2; i++) begin
      ind_wr(4'h5, {4'h8, tgt[i]});
      n = 0;
      while (load_cap_ready_flag !== 1'b1 && n < 300) begin
        @(posedge clk);
        n++;
      end
      check(8'(n > 3), 8'h01);
      check(8'(osc_ctrl.load_cap), {4'h0, tgt[i]});
    end
    apb(1'b1, A_ADR, 8'h95);
    wait_idle();
    rdchk(A_DAT, 8'hcf);
    // start-up tail: gain on, bias doubling off, missing clock on
    crystal_valid_pin <= 1'b1;
    oscillator_fail_pin <= 1'b1;
    ind_wr(4'h4, 8'he8);
    check(8'(osc_ctrl.gain_enable), 8'h01);
    check(8'(osc_ctrl.bias_double), 8'h00);
    check(8'(osc_ctrl.missing_clock_enable), 8'h01);
    apb(1'b1, A_ADR, 8'h94);
    wait_idle();
    rdchk(A_DAT, 8'heb);
  endtask

  task automatic t_read();
    ind_wr(4'h9, 8'h5a);
    rdchk(A_ADR, 8'h1a);
    ind_wr(4'ha, 8'h3c);
    ind_wr(4'hb, 8'h77);
    apb(1'b1, A_ADR, 8'h99);
    // stall mid-transfer: busy must outlast the frozen cycles
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    apb(1'b0, A_ADR, 8'h00);
    check(8'(rd[7]), 8'h01);
    wait_idle();
    rdchk(A_DAT, 8'h5a);
    rdchk(A_ADR, 8'h1a);
  endtask

  // busy set once, each data read launches the next read
  task automatic t_autoread();
    apb(1'b1, A_ADR, 8'hd9);
    wait_idle();
    rdchk(A_DAT, 8'h5a);
    wait_idle();
    rdchk(A_DAT, 8'h3c);
    wait_idle();
    apb(1'b1, A_ADR, 8'h0b);
    rdchk(A_DAT, 8'h77);
    // short strobe now off: busy still high in the seventh cycle
    apb(1'b1, A_ADR, 8'h8b);
    repeat (5) @(posedge clk);
    apb(1'b0, A_ADR, 8'h00);
    check(8'(rd[7]), 8'h01);
    wait_idle();
    rdchk(A_DAT, 8'h77);
  endtask

  task automatic t_lock_disable();
    apb(1'b1, A_KEY, 8'h00);
    rdchk(A_KEY, rtc_pkg::STAT_LOCKED);
    rdchk(A_DAT, 8'h00);
    rdchk(A_KEY, rtc_pkg::STAT_DISABLED);
    apb(1'b1, A_KEY, rtc_pkg::KEY_FIRST);
    rdchk(A_KEY, rtc_pkg::STAT_DISABLED);
  endtask

  // short strobe comes back on, index and data survive the reset
  task automatic t_reset_keep();
    do_reset();
    rdchk(A_KEY, rtc_pkg::STAT_LOCKED);
    apb(1'b1, A_KEY, rtc_pkg::KEY_FIRST);
    apb(1'b1, A_KEY, rtc_pkg::KEY_SECOND);
    rdchk(A_ADR, 8'h1c);
    rdchk(A_DAT, 8'h77);
  endtask

  task automatic t_wrong_key();
    apb(1'b1, A_KEY, 8'h00);
    apb(1'b1, A_KEY, rtc_pkg::KEY_SECOND);
    rdchk(A_KEY, rtc_pkg::STAT_DISABLED);
    do_reset();
    apb(1'b1, A_KEY, rtc_pkg::KEY_FIRST);
    apb(1'b1, A_KEY, 8'h12);
    rdchk(A_KEY, rtc_pkg::STAT_DISABLED);
  endtask

  initial begin
    err_total = 0;
    check_count = 0;
    reset = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    crystal_valid_pin = 1'b0;
    oscillator_fail_pin = 1'b0;
    do_reset();
    t_unlock();
    t_osc();
    t_load_cap_setting();
    t_read();
    t_autoread();
    t_lock_disable();
    t_reset_keep();
    t_wrong_key();
    stop_test();
  end

  // the whole run needs a few thousand cycles at most
  initial begin
    #(25 * 30000);
    err_total++;
    $display("ERROR at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
